//--- hdl/rcdr_decoder_3to8.sv
/*
  one three-to-eight line decoder with an enable.
  assumes its inputs are already stable in the system clock domain.
*/
`timescale 1ns/1ps
module rcdr_decoder_3to8 (
  input  wire logic       enable,
  input  wire logic [2:0] sel,
  output logic      [7:0] onehot
);
  assign onehot = enable ? (8'h01 << sel) : 8'h00;
endmodule

//--- hdl/rcdr_pkg.sv
/*
  constants for the rom card address decode and read control block.
  assumes a 16-bit processor address, 8-bit words and sixteen 256-word chip positions.
*/
// Summary of operation
// - the processor supplies a 16-bit address, bit 0 least significant; the card decodes bits 8 to 15 on every access and latches bits 0 to 7 for the chips.
// - card_match is true only when the top four address bits equal the jumper pattern, each bit taken true or inverted.
// - address bits 8 to 11 pick one of sixteen chip positions, bit 11 choosing the decoder half and bits 8 to 10 its input.
// - the low eight address bits are latched under card_match and broadcast to every chip position.
// - rom_card_selected is true only when rom_card_enable_in, card_match and chip present were all true at the last strobe.
// - no chip enable is raised unless rom_card_selected is true.
// - mem_data_out is driven with the enabled chip's data only while rom_card_selected is true.
// - one presence setting per chip position is looked up by address bits 8 to 11, high when a chip is fitted.
// - the presence result is latched as chip present, and an empty position leaves the card unselected.
// - rw_card_enable_out is raised, latched, whenever rom_card_selected is false.
// - a fitted chip covering the address withholds rw_card_enable_out, so rom wins over ram.
// - a read has an addressing phase that decodes and enables one location, then a data phase returning the word.
package rcdr_pkg;
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int NUM_CHIPS   = 16;
  localparam int WORD_W      = 8;
  localparam int POS_W       = 4;
  localparam int WORD_LSB    = 0;
  localparam int POS_LSB     = 8;
  localparam int HALF_BIT    = 11;
  localparam int REGION_LSB  = 12;
  localparam int REGION_W    = 4;
  localparam logic [DATA_W-1:0]    DATA_RST    = 8'h00;
  localparam logic [NUM_CHIPS-1:0] ENABLE_RST  = 16'h0000;
  localparam logic [WORD_W-1:0]    WORD_RST    = 8'h00;
  localparam logic [POS_W-1:0]     POS_RST     = 4'h0;
  localparam logic                 RW_ENA_RST  = 1'b1;
endpackage

//--- hdl/rcdr_rom_card_decode_read.sv
/*
  address decode and read control for a sixteen-position rom card.
  assumes addr, strobe, enable and jumpers are external pins (double synchronised here)
  and chip_read_data returns data from the enabled position one clock after enable.
*/
`timescale 1ns/1ps
module rcdr_rom_card_decode_read
  import rcdr_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic [ADDR_BITS-1:0] mem_addr,
  input  wire logic                 addr_strobe,
  input  wire logic                 rom_card_enable_in,
  input  wire logic [REGION_W-1:0]  region_match_inputs,
  input  wire logic [NUM_CHIPS-1:0] chip_fitted,
  input  wire logic [DATA_W-1:0]    chip_read_data,
  output logic      [NUM_CHIPS-1:0] chip_enable,
  output logic      [WORD_W-1:0]    word_in_chip_addr,
  output logic      [DATA_W-1:0]    mem_data_out,
  output logic                      mem_data_out_en,
  output logic                      rom_card_selected,
  output logic                      rw_card_enable_out
);
  // two-stage synchronisers; first stage is read only by the second
  logic [ADDR_BITS-1:0] addr_s1_reg, addr_s2_reg;
  logic [1:0]           ctl_s1_reg, ctl_s2_reg;
  logic [REGION_W-1:0]  jmp_s1_reg, jmp_s2_reg;
  logic [NUM_CHIPS-1:0] fit_s1_reg, fit_s2_reg;
  logic                 strobe_d_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_s1_reg  <= '0;
      addr_s2_reg  <= '0;
      ctl_s1_reg   <= '0;
      ctl_s2_reg   <= '0;
      jmp_s1_reg   <= '0;
      jmp_s2_reg   <= '0;
      fit_s1_reg   <= '0;
      fit_s2_reg   <= '0;
      strobe_d_reg <= 1'b0;
    end else begin
      addr_s1_reg  <= mem_addr;
      addr_s2_reg  <= addr_s1_reg;
      ctl_s1_reg   <= {rom_card_enable_in, addr_strobe};
      ctl_s2_reg   <= ctl_s1_reg;
      jmp_s1_reg   <= region_match_inputs;
      jmp_s2_reg   <= jmp_s1_reg;
      fit_s1_reg   <= chip_fitted;
      fit_s2_reg   <= fit_s1_reg;
      strobe_d_reg <= ctl_s2_reg[0];
    end
  end

  // decode on synchronised address; jumpers set true/inverted sense per region bit
  wire                strobe_rise = ctl_s2_reg[0] && !strobe_d_reg;
  wire                enable_sync = ctl_s2_reg[1];
  wire [REGION_W-1:0] region_addr_bits = addr_s2_reg[REGION_LSB +: REGION_W];
  wire                card_match = (region_addr_bits ~^ jmp_s2_reg) == {REGION_W{1'b1}};
  wire [POS_W-1:0]    chip_position_addr = addr_s2_reg[POS_LSB +: POS_W];
  wire                fitted_here = fit_s2_reg[chip_position_addr];

  // latched decode, all taken on the same strobe edge
  logic [WORD_W-1:0] word_reg, word_next;
  logic [POS_W-1:0]  pos_reg, pos_next;
  logic              match_reg, present_reg, enable_reg;

  assign word_next = card_match ? addr_s2_reg[WORD_LSB +: WORD_W] : word_reg;
  assign pos_next  = chip_position_addr;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      word_reg    <= WORD_RST;
      pos_reg     <= POS_RST;
      match_reg   <= 1'b0;
      present_reg <= 1'b0;
      enable_reg  <= 1'b0;
    end else if (strobe_rise) begin
      word_reg    <= word_next;
      pos_reg     <= pos_next;
      match_reg   <= card_match;
      present_reg <= fitted_here;
      enable_reg  <= enable_sync;
    end
  end

  wire selected_next = enable_reg && match_reg && present_reg;
  wire [NUM_CHIPS-1:0] enables_next;

  // bit 11 picks which decoder half; empty positions never get selected
  rcdr_decoder_3to8 u_dec_lo (
    .enable (selected_next && !pos_reg[HALF_BIT-POS_LSB]),
    .sel    (pos_reg[2:0]),
    .onehot (enables_next[7:0])
  );
  rcdr_decoder_3to8 u_dec_hi (
    .enable (selected_next && pos_reg[HALF_BIT-POS_LSB]),
    .sel    (pos_reg[2:0]),
    .onehot (enables_next[15:8])
  );

  // data and its enable share one condition, so no stale word shows while undriven
  wire              drive_next = rom_card_selected && selected_next;
  wire [DATA_W-1:0] data_next  = drive_next ? chip_read_data : DATA_RST;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chip_enable        <= ENABLE_RST;
      word_in_chip_addr  <= WORD_RST;
      rom_card_selected  <= 1'b0;
      rw_card_enable_out <= RW_ENA_RST;
      mem_data_out       <= DATA_RST;
      mem_data_out_en    <= 1'b0;
    end else begin
      chip_enable        <= enables_next;
      word_in_chip_addr  <= word_reg;
      rom_card_selected  <= selected_next;
      rw_card_enable_out <= !selected_next;
      mem_data_out       <= data_next;
      mem_data_out_en    <= drive_next;
    end
  end

  // checks
  AST_SEL_NEEDS_ALL: assert property (@(posedge clk_sys) disable iff (!rstn)
    rom_card_selected |-> $past(enable_reg) && $past(match_reg) && $past(present_reg))
    else $error("selected without enable, match and presence");
  AST_NO_ENABLE_UNSELECTED: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rom_card_selected |-> chip_enable == ENABLE_RST)
    else $error("chip enable raised while unselected");
  AST_ONE_ENABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    rom_card_selected |-> $onehot(chip_enable) && chip_enable[$past(pos_reg)])
    else $error("chip enable not the addressed position");
  AST_DATA_GATED: assert property (@(posedge clk_sys) disable iff (!rstn)
    mem_data_out_en |-> $past(rom_card_selected) && mem_data_out == $past(chip_read_data))
    else $error("data driven without selection");
  AST_RAM_COMPLEMENT: assert property (@(posedge clk_sys) disable iff (!rstn)
    rw_card_enable_out != rom_card_selected)
    else $error("ram enable not complement of selection");
  AST_ROM_PRIORITY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (enable_reg && match_reg && present_reg) |=> !rw_card_enable_out)
    else $error("ram enabled over fitted rom");
  AST_EMPTY_UNSELECTED: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && !fitted_here) |=> ##1 !rom_card_selected)
    else $error("empty position selected");
  AST_MATCH_PATTERN: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && region_addr_bits != jmp_s2_reg) |=> !match_reg ##1 !rom_card_selected)
    else $error("card matched wrong region");
  AST_WORD_LATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && card_match) |=> ##1 word_in_chip_addr == $past(addr_s2_reg[7:0], 2))
    else $error("word address not broadcast");

  // latches move only on the synchronised strobe edge, so the data phase sees one decode
  AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    !strobe_rise |=> $stable(match_reg) && $stable(present_reg) && $stable(enable_reg) && $stable(pos_reg))
    else $error("decode latches moved without strobe");
  // the word latch ignores accesses aimed at another card
  AST_WORD_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && !card_match) |=> $stable(word_reg))
    else $error("word latch loaded without card match");
  // a matching access leaves its low address bits in the word latch
  AST_WORD_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && card_match) |=> word_reg == $past(addr_s2_reg[WORD_LSB +: WORD_W]))
    else $error("word latch missed matching address");
  // the broadcast copy trails the latch by one clock
  AST_WORD_BROADCAST: assert property (@(posedge clk_sys) disable iff (!rstn)
    word_in_chip_addr == $past(word_reg))
    else $error("word address broadcast differs from latch");
  // presence comes from the position bits of the same access, not a later one
  AST_PRESENT_LOOKUP: assert property (@(posedge clk_sys) disable iff (!rstn)
    strobe_rise |=> present_reg == $past(fit_s2_reg[addr_s2_reg[POS_LSB +: POS_W]]))
    else $error("presence latch not the addressed position");
  // every region bit equal to its jumper must give a match
  AST_MATCH_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && region_addr_bits == jmp_s2_reg) |=> match_reg)
    else $error("matching region not recognised");
  // the card enable is taken at the strobe edge, later changes are ignored
  AST_ENABLE_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    strobe_rise |=> enable_reg == $past(enable_sync))
    else $error("card enable not latched at strobe");
  // position latch holds the chip bits of the strobed address
  AST_POS_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    strobe_rise |=> pos_reg == $past(addr_s2_reg[POS_LSB +: POS_W]))
    else $error("position latch not the addressed position");
  // the top position bit picks the upper decoder
  AST_HALF_SELECT: assert property (@(posedge clk_sys) disable iff (!rstn)
    rom_card_selected |-> (|chip_enable[15:8]) == $past(pos_reg[HALF_BIT-POS_LSB]))
    else $error("wrong decoder half enabled");
  // two chips driving the data lines at once would fight
  AST_AT_MOST_ONE: assert property (@(posedge clk_sys) disable iff (!rstn)
    $onehot0(chip_enable))
    else $error("more than one chip enabled");
  // chip enables stand as long as the decode latches do
  AST_ENABLE_STABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($stable(pos_reg) && $stable(match_reg) && $stable(present_reg) && $stable(enable_reg))
    |=> $stable(chip_enable))
    else $error("chip enable moved between strobes");
  // an empty socket never sees a chip enable
  AST_FIT_BEHIND_ENABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (|chip_enable) |-> $past(present_reg))
    else $error("chip enabled at empty position");
  // ram enable is the registered inverse of the combined select terms
  AST_RW_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rstn)
    rw_card_enable_out == !$past(enable_reg && match_reg && present_reg))
    else $error("ram enable does not follow selection");
  // a refused card hands the access to the ram card
  AST_RW_ON_REFUSE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && !enable_sync) |=> ##1 rw_card_enable_out)
    else $error("ram enable withheld while card disabled");
  // enable, region and presence together must select the card
  AST_SEL_ON_HIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (strobe_rise && enable_sync && region_addr_bits == jmp_s2_reg && fit_s2_reg[addr_s2_reg[POS_LSB +: POS_W]])
    |=> ##1 rom_card_selected)
    else $error("card not selected for a fitted matching access");
  // data is only driven for a selected card
  AST_DATA_EN_NEEDS_SEL: assert property (@(posedge clk_sys) disable iff (!rstn)
    mem_data_out_en |-> rom_card_selected)
    else $error("data enable without selection");
  // undriven data lines rest at zero
  AST_DATA_ZERO_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !mem_data_out_en |-> mem_data_out == DATA_RST)
    else $error("data present while not driving");
  // dropping the selection stops driving in the same clock
  AST_DATA_OFF_AT_DESELECT: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(rom_card_selected) |-> !mem_data_out_en)
    else $error("data still driven after deselection");
endmodule

//--- verification/rcdr_cpu_model.sv
/*
  behavioural processor for the rom card bench: address, strobe and card enable.
  assumes the bench calls read_access and that pins change at the falling edge.
*/
`timescale 1ns/1ps
module rcdr_cpu_model
  import rcdr_pkg::*;
(
  input  wire logic              clk_sys,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   addr_strobe,
  output logic                   rom_card_enable_in
);
  initial begin
    mem_addr           = 16'h0000;
    addr_strobe        = 1'b0;
    rom_card_enable_in = 1'b0;
  end
  // gap stretches the idle time so prompt and slow processors are both seen
  task automatic read_access(input logic [ADDR_W-1:0] addr, input logic en, input int gap);
    @(negedge clk_sys);
    mem_addr           = addr;
    rom_card_enable_in = en;
    addr_strobe        = 1'b1;
    repeat (3) @(negedge clk_sys);
    addr_strobe        = 1'b0;
    repeat (4) @(negedge clk_sys);
    // the bus moves on after the strobe, so only latched state may carry the read
    mem_addr           = ~addr;
    rom_card_enable_in = ~en;
    repeat (2 + gap) @(negedge clk_sys);
  endtask
endmodule

//--- verification/rcdr_rom_card_decode_read_bench.sv
/*
  self-checking bench for the rom card decode and read control block.
  assumes the processor model beside it; the chip array is modelled here.
*/
`timescale 1ns/1ps
module rcdr_rom_card_decode_read_bench;
  import rcdr_pkg::*;
  logic                 clk_sys = 1'b0;
  logic                 rstn = 1'b0;
  logic [ADDR_W-1:0]    mem_addr;
  logic                 addr_strobe;
  logic                 rom_card_enable_in;
  logic [REGION_W-1:0]  region_match_inputs = 4'h0;
  logic [NUM_CHIPS-1:0] chip_fitted = 16'h0000;
  logic [DATA_W-1:0]    chip_read_data;
  logic [NUM_CHIPS-1:0] chip_enable;
  logic [WORD_W-1:0]    word_in_chip_addr;
  logic [DATA_W-1:0]    mem_data_out;
  logic                 mem_data_out_en;
  logic                 rom_card_selected;
  logic                 rw_card_enable_out;
  int                   failures = 0;
  int                   comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  rcdr_rom_card_decode_read u_rcdr_rom_card_decode_read (.clk_sys(clk_sys), .rstn(rstn), .mem_addr(mem_addr),
    .addr_strobe(addr_strobe), .rom_card_enable_in(rom_card_enable_in), .region_match_inputs(region_match_inputs),
    .chip_fitted(chip_fitted), .chip_read_data(chip_read_data), .chip_enable(chip_enable),
    .word_in_chip_addr(word_in_chip_addr), .mem_data_out(mem_data_out), .mem_data_out_en(mem_data_out_en),
    .rom_card_selected(rom_card_selected), .rw_card_enable_out(rw_card_enable_out));
  rcdr_cpu_model u_rcdr_cpu_model (.clk_sys(clk_sys), .mem_addr(mem_addr), .addr_strobe(addr_strobe),
    .rom_card_enable_in(rom_card_enable_in));
  // contents differ per position so a wrong chip enable shows in the data
  always_comb begin
    chip_read_data = DATA_RST;
    for (int i = 0; i < NUM_CHIPS; i++) if (chip_enable[i]) chip_read_data = word_in_chip_addr ^ 8'(i * 17);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end
  initial begin
    logic [15:0] a;
    logic        en;
    logic        sel;
    int          pos;
    logic [7:0]  word_exp;
    void'($urandom(89398));
    word_exp = WORD_RST;
    repeat (2) @(negedge clk_sys);
    check(rw_card_enable_out, 1'b1);
    check(rom_card_selected, 1'b0);
    rstn = 1'b1;
    for (int n = 0; n < 300; n++) begin
      if (n == 150) begin
        rstn = 1'b0;
        word_exp = WORD_RST;
        repeat (2) @(negedge clk_sys);
        check(rw_card_enable_out, 1'b1);
        check(chip_enable, 16'h0000);
        check(mem_data_out_en, 1'b0);
        rstn = 1'b1;
      end
      region_match_inputs = 4'($urandom);
      chip_fitted = (n < 20) ? 16'hFFFF : 16'($urandom);
      a = 16'($urandom);
      if (n % 4 != 3) a[15:12] = region_match_inputs;
      en = (n % 8 != 7);
      pos = int'(a[11:8]);
      sel = en && a[15:12] == region_match_inputs && chip_fitted[pos];
      if (a[15:12] == region_match_inputs) word_exp = a[7:0];
      u_rcdr_cpu_model.read_access(a, en, int'($urandom % 3));
      check(rom_card_selected, sel);
      check(chip_enable, sel ? 16'h0001 << pos : 16'h0000);
      check(word_in_chip_addr, word_exp);
      check(mem_data_out_en, sel);
      check(mem_data_out, sel ? a[7:0] ^ 8'(pos * 17) : 8'h00);
      check(rw_card_enable_out, !sel);
    end
    summarize();
  end
endmodule
